//--- hw/dvt_pkg.sv
// shared constants and types of the divide-by-twelve ripple counter
// assumes a single 25 MHz clock domain and pins sampled from outside it

package dvt_pkg;

	// ----------------------------------------------------------------
	// pin group layout
	// ----------------------------------------------------------------
	localparam int DVT_PINS = 4;
	localparam int DVT_IDX_HALF_CLK = 0;
	localparam int DVT_IDX_SIXTH_CLK = 1;
	localparam int DVT_IDX_CLEAR_A = 2;
	localparam int DVT_IDX_CLEAR_B = 3;

	// ----------------------------------------------------------------
	// counter layout and reset values
	// ----------------------------------------------------------------
	localparam int DVT_STAGES = 4;
	localparam logic DVT_BIT_RESET = 1'b0;
	localparam logic [DVT_STAGES-1:0] DVT_COUNT_RESET = 4'h0;
	localparam logic DVT_PIN_RESET = 1'b0;

	// divide-by-three part of the divide-by-six section, one-hot
	typedef enum logic [2:0]
	{
		DVT_THIRD_ZERO = 3'b001,
		DVT_THIRD_ONE = 3'b010,
		DVT_THIRD_TWO = 3'b100
	} dvt_third_t;

endpackage : dvt_pkg

//--- hw/dvt_pin_if.sv
// filtered pin levels and their falling-edge pulses
// assumes the filter and the counter core share one clock

interface dvt_pin_if
	import dvt_pkg::*;
();
	// level after the agreement filter, and a one-cycle fall pulse
	wire logic [DVT_PINS-1:0] lvl;
	wire logic [DVT_PINS-1:0] fall;

	modport src
	(
		output lvl,
		output fall
	);

	modport snk
	(
		input lvl,
		input fall
	);
endinterface : dvt_pin_if

//--- hw/dvt_pin_filter.sv
// three-flop synchroniser and agreement filter for the counter pins
// assumes pins are asynchronous to clk and reset is already synchronised

module dvt_pin_filter
	import dvt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [DVT_PINS-1:0] pin_raw,
	dvt_pin_if.src pins
);

	// ----------------------------------------------------------------
	// one synchroniser per pin
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DVT_PINS; gi++)
		begin : g_pin
			logic meta;
			logic sync_a;
			logic sync_b;
			logic level;
			wire logic agree;

			// second and third flops must match before the level moves
			assign agree = (sync_a == sync_b);

			// chain of three flops; the first feeds only the second
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta <= DVT_PIN_RESET;
					sync_a <= DVT_PIN_RESET;
					sync_b <= DVT_PIN_RESET;
				end
				else
				begin
					meta <= pin_raw[gi];
					sync_a <= meta;
					sync_b <= sync_a;
				end
			end

			// filtered level follows only agreed values
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					level <= DVT_PIN_RESET;
				else if (agree)
					level <= sync_b;
			end

			assign pins.lvl[gi] = level;
			// high-to-low of the filtered level, one cycle wide
			assign pins.fall[gi] = level & agree & ~sync_b;
		end
	endgenerate

endmodule : dvt_pin_filter

//--- hw/dvt_counter.sv
// divide-by-twelve ripple counter: divide-by-two plus divide-by-six
// assumes clk at 25 MHz; count and clear pins arrive asynchronously

module dvt_counter
	import dvt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic half_section_clock_n,
	input wire logic sixth_section_clock_n,
	input wire logic clear_input_a,
	input wire logic clear_input_b,
	output logic count_bit_zero,
	output logic count_bit_one,
	output logic count_bit_two,
	output logic count_bit_three
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_n;
	logic rst_sync_n;

	// asynchronous assert, release through two flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ----------------------------------------------------------------
	// pin filtering
	// ----------------------------------------------------------------
	dvt_pin_if pins ();
	wire logic [DVT_PINS-1:0] pin_raw;

	assign pin_raw[DVT_IDX_HALF_CLK] = half_section_clock_n;
	assign pin_raw[DVT_IDX_SIXTH_CLK] = sixth_section_clock_n;
	assign pin_raw[DVT_IDX_CLEAR_A] = clear_input_a;
	assign pin_raw[DVT_IDX_CLEAR_B] = clear_input_b;

	dvt_pin_filter u_filter
	(
		.clk(clk),
		.rst_n(rst_sync_n),
		.pin_raw(pin_raw),
		.pins(pins.src)
	);

	// ----------------------------------------------------------------
	// decode of clear and section clock edges
	// ----------------------------------------------------------------
	wire logic clear_on;
	wire logic half_fall;
	wire logic sixth_fall;
	wire logic two_fall;

	logic two_prev;
	dvt_third_t third;
	dvt_third_t next_third;

	// clear needs both inputs high; one low leaves counting alone
	assign clear_on = pins.lvl[DVT_IDX_CLEAR_A] &
		pins.lvl[DVT_IDX_CLEAR_B];
	// each section sees only its own pin; bit zero never feeds the
	// sixth section inside, so chaining is done by outside wiring
	assign half_fall = pins.fall[DVT_IDX_HALF_CLK];
	assign sixth_fall = pins.fall[DVT_IDX_SIXTH_CLK];
	// bit two falling clocks the last stage one cycle later
	assign two_fall = two_prev & ~count_bit_two;

	// ----------------------------------------------------------------
	// divide-by-two section
	// ----------------------------------------------------------------
	// toggles on its own clock fall, cleared while clear is on
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			count_bit_zero <= DVT_BIT_RESET;
		else if (clear_on)
			count_bit_zero <= DVT_BIT_RESET;
		else if (half_fall)
			count_bit_zero <= ~count_bit_zero;
	end

	// ----------------------------------------------------------------
	// divide-by-six section: divide-by-three then divide-by-two
	// ----------------------------------------------------------------
	// one-hot walk zero, one, two, zero on each sixth-clock fall
	always_comb
	begin
		case (third)
			DVT_THIRD_ZERO: next_third = DVT_THIRD_ONE;
			DVT_THIRD_ONE: next_third = DVT_THIRD_TWO;
			DVT_THIRD_TWO: next_third = DVT_THIRD_ZERO;
			default: next_third = DVT_THIRD_ZERO;
		endcase
	end

	// clear wins over any clock; edge only advances once clear is off
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			third <= DVT_THIRD_ZERO;
		else if (clear_on)
			third <= DVT_THIRD_ZERO;
		else if (sixth_fall)
			third <= next_third;
	end

	// bits one and two read straight from the one-hot flops
	assign count_bit_one = third[1];
	assign count_bit_two = third[2];

	// last stage toggles on bit two falling, a ripple behind
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			two_prev <= DVT_BIT_RESET;
			count_bit_three <= DVT_BIT_RESET;
		end
		else if (clear_on)
		begin
			two_prev <= DVT_BIT_RESET;
			count_bit_three <= DVT_BIT_RESET;
		end
		else
		begin
			two_prev <= count_bit_two;
			if (two_fall)
				count_bit_three <= ~count_bit_three;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	wire logic [DVT_STAGES-1:0] count_all;

	assign count_all = {count_bit_three, count_bit_two,
		count_bit_one, count_bit_zero};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_n);

	// clear drives every bit low on the next edge
	a_clear_forces_low:
		assert property (clear_on |=> count_all == DVT_COUNT_RESET)
		else $error("clear did not force the count low");

	// nothing moves without a clock edge or a qualified clear
	a_hold_no_edge:
		assert property ((!clear_on && !half_fall && !sixth_fall
			&& !two_fall) |=> $stable(count_all))
		else $error("count changed without an edge or clear");

	// first stage flips on each own-clock fall
	a_half_toggles:
		assert property ((!clear_on && half_fall)
			|=> count_bit_zero != $past(count_bit_zero))
		else $error("bit zero missed its clock fall");

	// first stage ignores the sixth-section clock
	a_half_isolated:
		assert property ((!clear_on && !half_fall && sixth_fall)
			|=> $stable(count_bit_zero))
		else $error("bit zero moved on the sixth clock");

	// divide-by-three steps once per sixth-clock fall
	a_third_steps:
		assert property ((!clear_on && sixth_fall)
			|=> third == {$past(third[1:0]), $past(third[2])})
		else $error("divide-by-three step wrong");

	// last stage toggles two edges after the sixth-clock fall that wraps two to zero
	a_three_ripple:
		assert property ((!clear_on && sixth_fall
			&& third == DVT_THIRD_TWO) ##1 !clear_on
			|=> count_bit_three != $past(count_bit_three, 2))
		else $error("bit three did not ripple after bit two fell");

	// bits one and two never high together, state stays one-hot
	a_third_legal:
		assert property (!(count_bit_one && count_bit_two)
			&& $onehot(third))
		else $error("illegal divide-by-six code");

	// last stage only moves on bit two falling or clear
	a_three_cause:
		assert property ((!clear_on && !two_fall)
			|=> $stable(count_bit_three))
		else $error("bit three moved without bit two falling");

	// release leaves the count at zero until the next fall
	a_release_zero:
		assert property ((clear_on ##1 !clear_on)
			|-> count_all == DVT_COUNT_RESET)
		else $error("count not zero at clear release");

	cover_clear_release:
		cover property (clear_on ##1 !clear_on ##[1:20] half_fall);
	cover_three_rise:
		cover property (two_fall && !clear_on ##1 count_bit_three);
	cover_full_wrap:
		cover property (count_bit_three && count_bit_two
			&& count_bit_zero ##[1:50] count_all == DVT_COUNT_RESET);

endmodule : dvt_counter

//--- bench/dvt_pulse_src.sv
// count pulse source standing outside the divide-by-twelve counter
// assumes tb calls pulse(); pins move on the falling edge of clk, except a wired sixth pin following bit zero

module dvt_pulse_src
(
	input wire logic clk,
	input wire logic wired,
	input wire logic count_bit_zero,
	output logic half_section_clock_n,
	output logic sixth_section_clock_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// pin levels
	// ----------------------------------------------------------------
	// index 0 drives the half section, index 1 the sixth section
	logic [1:0] lvl;

	// both pin levels idle high from time zero; a wired sixth clock follows bit zero instead
	initial
	begin
		lvl = 2'b11;
	end

	// idle high, so only the drop of a pulse counts
	assign half_section_clock_n = lvl[0];
	// chaining takes the raw first output, never a decode of the count
	assign sixth_section_clock_n = wired ? count_bit_zero : lvl[1];

	// ----------------------------------------------------------------
	// pulse generation
	// ----------------------------------------------------------------
	// low for four cycles, then high with fourteen cycles of room for the ripple
	task automatic pulse(input int sel);
		@(negedge clk);
		lvl[sel] = 1'b0;
		repeat (4) @(negedge clk);
		lvl[sel] = 1'b1;
		repeat (14) @(negedge clk);
	endtask : pulse
endmodule : dvt_pulse_src

//--- bench/tb.sv
// self-checking bench for the divide-by-twelve ripple counter
// assumes dvt_pulse_src supplies the count pulses; clears come from here

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// stimulus and observation
	// ----------------------------------------------------------------
	logic clk;
	logic rst_n;
	logic wired;
	logic clear_input_a;
	logic clear_input_b;
	wire logic half_clk_n;
	wire logic sixth_clk_n;
	wire logic b0;
	wire logic b1;
	wire logic b2;
	wire logic b3;
	logic [3:0] seen;
	int bad_count = 0;
	int checks = 0;

	// the four outputs as one count, bit three on top
	assign seen = {b3, b2, b1, b0};

	dvt_counter uut
	(
		.clk(clk),
		.rst_n(rst_n),
		.half_section_clock_n(half_clk_n),
		.sixth_section_clock_n(sixth_clk_n),
		.clear_input_a(clear_input_a),
		.clear_input_b(clear_input_b),
		.count_bit_zero(b0),
		.count_bit_one(b1),
		.count_bit_two(b2),
		.count_bit_three(b3)
	);

	dvt_pulse_src src
	(
		.clk(clk),
		.wired(wired),
		.count_bit_zero(b0),
		.half_section_clock_n(half_clk_n),
		.sixth_section_clock_n(sixth_clk_n)
	);

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	// compare the settled outputs against an expected count
	task automatic chk(input string what, input logic [3:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// print the counts and the verdict, then stop
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// chained through bit zero: twelve pulses walk the table and wrap
	task automatic run_mod12();
		logic [3:0] seq [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8,
			4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'h0};
		for (int k = 0; k < 12; k++)
		begin
			src.pulse(0);
			chk("modulo-12 count", seq[k]);
		end
	endtask : run_mod12

	// unchained: each section only follows its own clock
	task automatic run_split();
		logic [2:0] six [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h0};
		logic b0x;
		b0x = 1'b0;
		wired = 1'b0;
		repeat (4) @(negedge clk);
		for (int k = 0; k < 6; k++)
		begin
			src.pulse(1);
			chk("sixth section", {six[k], b0x});
			src.pulse(0);
			b0x = ~b0x;
			chk("half section", {six[k], b0x});
		end
	endtask : run_split

	// single clear inputs do nothing; both together clear and hold
	task automatic run_clear();
		src.pulse(0);
		src.pulse(1);
		chk("before clear", 4'h3);
		clear_input_a = 1'b1;
		src.pulse(0);
		chk("clear a alone", 4'h2);
		clear_input_a = 1'b0;
		clear_input_b = 1'b1;
		src.pulse(1);
		chk("clear b alone", 4'h4);
		clear_input_a = 1'b1;
		repeat (8) @(negedge clk);
		chk("clear applied", 4'h0);
		src.pulse(0);
		src.pulse(1);
		chk("clocks during clear", 4'h0);
		clear_input_a = 1'b0;
		clear_input_b = 1'b0;
		repeat (8) @(negedge clk);
		chk("clear released", 4'h0);
		src.pulse(0);
		chk("first count after clear", 4'h1);
	endtask : run_clear

	// ----------------------------------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------------------------------
	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end

	// reset for eight cycles, then the scenarios in turn
	initial
	begin
		rst_n = 1'b0;
		wired = 1'b1;
		clear_input_a = 1'b0;
		clear_input_b = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk("after reset", 4'h0);
		run_mod12();
		run_split();
		run_clear();
		wrap_up();
	end
endmodule : tb
